// ### watchdog_pkg.sv
// Shared constants and types for the watchdog timer and its controller
package watchdog_pkg;
  // ----------------------------------------------------------------
  // Counter and control/status layout
  // ----------------------------------------------------------------
  localparam int COUNT_WIDTH = 8;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int FLAG_BIT = 7;
  localparam int MODE_BIT = 6;
  localparam int ENABLE_BIT = 5;
  localparam int SOURCE_BIT = 4;
  localparam int ACTION_BIT = 3;
  localparam int CKS_MSB = 2;
  localparam int CKS_LSB = 0;
  // Protected write keys, carried beside the write data
  localparam logic [7:0] KEY_COUNTER = 8'h5a;
  localparam logic [7:0] KEY_CSR = 8'ha5;
  localparam logic SEL_COUNTER = 1'b0;
  localparam logic SEL_CSR = 1'b1;
  // ----------------------------------------------------------------
  // Prescaler: tap bit whose falling edge gives divide by 2..131072
  // ----------------------------------------------------------------
  localparam int PRESCALE_WIDTH = 17;
  localparam int PRESCALE_TAP [8] = '{0, 5, 6, 8, 10, 12, 14, 16};
  localparam int RESET_OUT_CYCLES = 16;
  // ----------------------------------------------------------------
  // Controller register map (byte addresses) and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_COUNTER = 4'h0;
  localparam logic [3:0] OFS_CSR = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
  localparam int IRQ_WIDTH = 3;
  localparam int IRQ_NMI = 0;
  localparam int IRQ_INTERVAL = 1;
  localparam int IRQ_RESET = 2;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS, BUS_DONE} bus_state_t;
endpackage

// ### watchdog_link_if.sv
// Link between the watchdog timer and its controller
`timescale 1ns/10ps
interface watchdog_link_if;
  logic acc_rd;
  logic acc_wr;
  logic acc_sel;
  logic [7:0] acc_key;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic reset_req;
  logic nmi_req;
  logic interval_irq;
  modport dev (
    input acc_rd, acc_wr, acc_sel, acc_key, acc_wdata,
    output acc_rdata, reset_req, nmi_req, interval_irq
  );
  modport ctl (
    output acc_rd, acc_wr, acc_sel, acc_key, acc_wdata,
    input acc_rdata, reset_req, nmi_req, interval_irq
  );
endinterface

// ### watchdog_interval_timer.sv
// Watchdog / interval timer channel with protected register port
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module watchdog_interval_timer
  import watchdog_pkg::*;
#(
  parameter bit HAS_SUB_CLOCK = 1'b1,
  parameter int RESET_OUT_LEN = RESET_OUT_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SUB_CLOCK_IN,
  output logic RESET_OUT_N_OUT,
  watchdog_link_if.dev link
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] watchdog_counter;
  logic overflow_flag;
  logic timer_mode_select;
  logic count_enable_bit;
  logic source_select;
  logic action_select;
  logic [2:0] clock_select_field;
  logic clear_armed;
  logic [PRESCALE_WIDTH-1:0] main_prescale;
  logic [PRESCALE_WIDTH-1:0] sub_prescale;
  logic sub_prev;
  logic tap_prev;
  logic [7:0] reset_out_count;
  logic reset_req;
  logic nmi_req;
  logic interval_irq;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // A write lands only with the matching key; a bad key is dropped silently
  wire counter_write = link.acc_wr & (link.acc_sel == SEL_COUNTER)
                       & (link.acc_key == KEY_COUNTER);
  wire csr_write = link.acc_wr & (link.acc_sel == SEL_CSR)
                   & (link.acc_key == KEY_CSR);
  wire csr_read = link.acc_rd & (link.acc_sel == SEL_CSR);
  wire [7:0] wdata = link.acc_wdata;
  wire sub_edge = SUB_CLOCK_IN & ~sub_prev;

  // Reserved bit 4 on the channel without a sub-clock reads zero
  wire source_bit = HAS_SUB_CLOCK ? source_select : 1'b0;
  wire [7:0] csr_value = {overflow_flag, timer_mode_select, count_enable_bit,
                          source_bit, action_select, clock_select_field};
  assign link.acc_rdata = (link.acc_sel == SEL_CSR) ? csr_value
                          : watchdog_counter;

  // ----------------------------------------------------------------
  // Prescaler tap and count tick
  // ----------------------------------------------------------------
  // The tick is the falling edge of the chosen tap, so changing the select
  // from a high tap to a low one may give one extra count, as users expect
  wire main_tap = main_prescale[PRESCALE_TAP[clock_select_field]];
  wire sub_tap = sub_prescale[PRESCALE_TAP[clock_select_field]];
  wire tap_level = (HAS_SUB_CLOCK && source_select) ? sub_tap : main_tap;
  wire count_tick = tap_prev & ~tap_level;

  // A counter write wins over a count-up in the same cycle
  wire count_up = count_enable_bit & count_tick & ~counter_write;
  wire overflow = count_up & (watchdog_counter == COUNTER_MAX);
  wire reset_mode = timer_mode_select & action_select;

  // ----------------------------------------------------------------
  // Flag control
  // ----------------------------------------------------------------
  wire flag_clear_write = csr_write & clear_armed & ~wdata[FLAG_BIT];
  wire enable_clear_write = csr_write & ~wdata[ENABLE_BIT];
  // In reset mode the internal reset that follows the request clears it
  wire flag_internal_clear = reset_req;
  wire flag_clear = flag_clear_write | enable_clear_write | flag_internal_clear;
  // Set wins over every clear so an overflow is never lost
  wire next_flag = overflow | (overflow_flag & ~flag_clear);
  wire arm_now = csr_read & overflow_flag;
  wire next_armed = next_flag & (arm_now | (clear_armed & ~flag_clear));

  // ----------------------------------------------------------------
  // Free-running prescalers
  // ----------------------------------------------------------------
  // Sub-clock is taken as synchronous; its rising edges step its prescaler
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      main_prescale <= '0;
      sub_prescale <= '0;
      sub_prev <= 1'b0;
      tap_prev <= 1'b0;
    end else begin
      main_prescale <= main_prescale + 1'b1;
      if (sub_edge) begin
        sub_prescale <= sub_prescale + 1'b1;
      end
      sub_prev <= SUB_CLOCK_IN;
      tap_prev <= tap_level;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Disable holds the counter at zero and also overrides a counter write
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      watchdog_counter <= COUNTER_RESET;
    end else if (!count_enable_bit) begin
      watchdog_counter <= COUNTER_RESET;
    end else if (counter_write) begin
      watchdog_counter <= wdata;
    end else if (count_up) begin
      watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control/status register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      timer_mode_select <= CSR_RESET[MODE_BIT];
      count_enable_bit <= CSR_RESET[ENABLE_BIT];
      source_select <= CSR_RESET[SOURCE_BIT];
      action_select <= CSR_RESET[ACTION_BIT];
      clock_select_field <= CSR_RESET[CKS_MSB:CKS_LSB];
    end else if (csr_write) begin
      timer_mode_select <= wdata[MODE_BIT];
      count_enable_bit <= wdata[ENABLE_BIT];
      source_select <= HAS_SUB_CLOCK ? wdata[SOURCE_BIT] : 1'b0;
      action_select <= wdata[ACTION_BIT];
      clock_select_field <= wdata[CKS_MSB:CKS_LSB];
    end
  end

  // Overflow flag and its read-before-clear arming
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      overflow_flag <= CSR_RESET[FLAG_BIT];
      clear_armed <= 1'b0;
    end else begin
      overflow_flag <= next_flag;
      clear_armed <= next_armed;
    end
  end

  // ----------------------------------------------------------------
  // Overflow requests
  // ----------------------------------------------------------------
  // Exactly one of the three pulses per overflow, each one cycle long
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      reset_req <= 1'b0;
      nmi_req <= 1'b0;
      interval_irq <= 1'b0;
    end else begin
      reset_req <= overflow & reset_mode;
      nmi_req <= overflow & timer_mode_select & ~action_select;
      interval_irq <= overflow & ~timer_mode_select;
    end
  end
  assign link.reset_req = reset_req;
  assign link.nmi_req = nmi_req;
  assign link.interval_irq = interval_irq;

  // ----------------------------------------------------------------
  // Reset output pin
  // ----------------------------------------------------------------
  // Low for a fixed stretch so slow external parts see the reset
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      reset_out_count <= 8'h00;
    end else if (overflow && reset_mode) begin
      reset_out_count <= 8'(RESET_OUT_LEN);
    end else if (reset_out_count != 8'h00) begin
      reset_out_count <= reset_out_count - 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RESET_OUT_N_OUT <= 1'b1;
    end else begin
      RESET_OUT_N_OUT <= ~((overflow && reset_mode)
                           || (reset_out_count > 8'h01));
    end
  end
endmodule

// ### watchdog_controller.sv
// Avalon-MM controller that drives the watchdog link and gathers its events
`timescale 1ns/10ps
module watchdog_controller
  import watchdog_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic IRQ_OUT,
  watchdog_link_if.ctl link
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bus_state_t state;
  logic acc_rd;
  logic acc_wr;
  logic acc_sel;
  logic [7:0] acc_wdata;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire request = AVS_READ_IN | AVS_WRITE_IN;
  wire hit_counter = (AVS_ADDRESS_IN == OFS_COUNTER);
  wire hit_csr = (AVS_ADDRESS_IN == OFS_CSR);
  wire hit_link = hit_counter | hit_csr;
  wire hit_status = (AVS_ADDRESS_IN == OFS_IRQ_STATUS);
  wire hit_mask = (AVS_ADDRESS_IN == OFS_IRQ_MASK);
  // Local effects land on the finishing edge, matching the master's view
  wire finish = (state == BUS_DONE);
  wire status_read = finish & AVS_READ_IN & hit_status;
  wire mask_write = finish & AVS_WRITE_IN & hit_mask;
  wire [IRQ_WIDTH-1:0] events = {link.reset_req, link.interval_irq, link.nmi_req};
  // Fill the key in so every software write passes the protection
  wire [7:0] write_key = hit_csr ? KEY_CSR : KEY_COUNTER;
  wire [31:0] local_data = hit_status ? {29'h0, irq_status}
                           : hit_mask ? {29'h0, irq_mask} : 32'h0;

  assign link.acc_rd = acc_rd;
  assign link.acc_wr = acc_wr;
  assign link.acc_sel = acc_sel;
  assign link.acc_key = write_key;
  assign link.acc_wdata = acc_wdata;
  assign AVS_WAITREQUEST_OUT = request & ~finish;
  assign IRQ_OUT = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Bus sequencer: idle, one link access cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state <= BUS_IDLE;
    end else begin
      unique case (state)
        BUS_IDLE: begin
          if (request) begin
            state <= BUS_ACCESS;
          end
        end
        BUS_ACCESS: begin
          state <= BUS_DONE;
        end
        BUS_DONE: begin
          state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Link strobes stand for exactly the access cycle
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      acc_rd <= 1'b0;
      acc_wr <= 1'b0;
      acc_sel <= SEL_COUNTER;
      acc_wdata <= 8'h00;
    end else begin
      acc_rd <= (state == BUS_IDLE) & AVS_READ_IN & hit_link;
      acc_wr <= (state == BUS_IDLE) & AVS_WRITE_IN & hit_link;
      acc_sel <= hit_csr ? SEL_CSR : SEL_COUNTER;
      acc_wdata <= AVS_WRITEDATA_IN[7:0];
    end
  end

  // Read data captured at the end of the access cycle
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      AVS_READDATA_OUT <= 32'h0;
    end else if (state == BUS_ACCESS) begin
      AVS_READDATA_OUT <= hit_link ? {24'h0, link.acc_rdata} : local_data;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // A read clears only the bits it reported, so an event landing during the read survives
  wire [IRQ_WIDTH-1:0] status_taken = status_read ? AVS_READDATA_OUT[IRQ_WIDTH-1:0] : '0;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= events | (irq_status & ~status_taken);
      if (mask_write) begin
        irq_mask <= AVS_WRITEDATA_IN[IRQ_WIDTH-1:0];
      end
    end
  end
endmodule

// ### watchdog_link_chk.sv
// Concurrent checks on the watchdog link and the reset pin
`timescale 1ns/10ps
module watchdog_link_chk
  import watchdog_pkg::*;
#(
  parameter int RESET_OUT_LEN = RESET_OUT_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic acc_sel,
  input wire logic [7:0] acc_key,
  input wire logic reset_req,
  input wire logic nmi_req,
  input wire logic interval_irq,
  input wire logic RESET_OUT_N_OUT
);
  // ------------------------------------------------------------
  // Pin low-time counter
  // ------------------------------------------------------------
  // Nine bits so a stuck-low pin cannot wrap back to a legal length
  logic [8:0] low_cnt;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      low_cnt <= 9'h000;
    end else begin
      low_cnt <= RESET_OUT_N_OUT ? 9'h000 : low_cnt + 9'h001;
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  // ------------------------------------------------------------
  // Assertions and covers
  // ------------------------------------------------------------
  a_reset_one_pulse: assert property (reset_req |=> !reset_req)
    else $error("reset request longer than one cycle");
  a_nmi_one_pulse: assert property (nmi_req |=> !nmi_req)
    else $error("nmi request longer than one cycle");
  a_interval_one_pulse: assert property (interval_irq |=> !interval_irq)
    else $error("interval interrupt longer than one cycle");
  a_single_request: assert property ($onehot0({reset_req, nmi_req, interval_irq}))
    else $error("more than one overflow request at once");
  a_pin_with_request: assert property ($fell(RESET_OUT_N_OUT) |-> ##[0:2] reset_req)
    else $error("reset pin fell without a reset request");
  a_request_pin_low: assert property (reset_req |-> !RESET_OUT_N_OUT)
    else $error("reset request with reset pin high");
  a_pin_low_length: assert property ($rose(RESET_OUT_N_OUT) |-> low_cnt == RESET_OUT_LEN)
    else $error("reset pin low time wrong");
  a_key_matches: assert property (acc_wr |-> acc_key == (acc_sel ? KEY_CSR : KEY_COUNTER))
    else $error("protected write carries wrong key");
  a_rd_wr_apart: assert property (!(acc_rd && acc_wr))
    else $error("read and write strobes together");
  c_reset: cover property (reset_req);
  c_nmi: cover property (nmi_req);
  c_interval: cover property (interval_irq);
  c_csr_write: cover property (acc_wr && acc_sel == SEL_CSR);
endmodule

// ### watchdog_interval_timer_bench.sv
// Self-checking bench joining the watchdog timer to its controller
`timescale 1ns/10ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module watchdog_interval_timer_bench
  import watchdog_pkg::*;
;
  // Short pin length so a wrong count is easy to tell from the default
  localparam int PIN_LEN = 6;
  localparam int LIMIT = 60000;
  logic clk, arst_n, sub_clk, rd, wr, waitreq, irq, pin_n;
  logic [3:0] address;
  logic [31:0] wdata, rdata, q;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  watchdog_link_if link ();
  watchdog_interval_timer #(.HAS_SUB_CLOCK(1'b1), .RESET_OUT_LEN(PIN_LEN))
    u_watchdog_interval_timer (.CLK_IN(clk), .ARST_N_IN(arst_n), .SUB_CLOCK_IN(sub_clk),
    .RESET_OUT_N_OUT(pin_n), .link(link));
  watchdog_controller u_watchdog_controller (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .AVS_ADDRESS_IN(address), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .IRQ_OUT(irq), .link(link));
  watchdog_link_chk #(.RESET_OUT_LEN(PIN_LEN)) u_watchdog_link_chk (.CLK_IN(clk),
    .ARST_N_IN(arst_n), .acc_rd(link.acc_rd), .acc_wr(link.acc_wr), .acc_sel(link.acc_sel),
    .acc_key(link.acc_key), .reset_req(link.reset_req), .nmi_req(link.nmi_req),
    .interval_irq(link.interval_irq), .RESET_OUT_N_OUT(pin_n));
  // ------------------------------------------------------------
  // Clock, timeout and closing report
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Guards against a waitrequest that never drops; interrupt waits have their own bound
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      $display("ERROR %0t: run timed out", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Avalon access tasks
  // ------------------------------------------------------------
  // Request held until waitrequest is seen low; one idle edge after release
  // A slave that never answers is caught by the run timeout, not here
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    address <= a;
    rd <= ~w;
    wr <= w;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put_reg(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic expect_rd(input logic [3:0] a, input logic [7:0] e);
    bus(a, 1'b0, 32'h0);
    `CHECK(q[7:0], e)
  endtask
  // Bounded wait for the interrupt (0) or the reset pin (1) to reach a level
  task automatic wait_for(input int which, input logic lvl);
    int n;
    n = 0;
    while (((which == 0) ? irq : pin_n) !== lvl && n < 700) begin
      @(posedge clk);
      n++;
    end
    if (n >= 700) begin
      miscompares++;
      $display("ERROR %0t: wait for level timed out", $time);
    end
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    // Non-blocking so every flop is already waiting when reset falls
    arst_n <= 1'b0;
    sub_clk <= 1'b0;
    rd <= 1'b0;
    wr <= 1'b0;
    address <= 4'h0;
    wdata <= 32'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    `CHECK(pin_n, 1'b1)
    expect_rd(OFS_COUNTER, 8'h00);
    expect_rd(OFS_CSR, 8'h00);
    // Slowest divider keeps the counter still while it is read back
    put_reg(OFS_CSR, 32'h27);
    put_reg(OFS_COUNTER, 32'ha7);
    expect_rd(OFS_COUNTER, 8'ha7);
    put_reg(4'h2, 32'h55);
    expect_rd(4'h2, 8'h00);
    expect_rd(OFS_COUNTER, 8'ha7);
    put_reg(OFS_CSR, 32'h07);
    expect_rd(OFS_COUNTER, 8'h00);
    $display("test register_access done");
    put_reg(OFS_IRQ_MASK, 32'h7);
    put_reg(OFS_CSR, 32'h20);
    put_reg(OFS_COUNTER, 32'hfe);
    wait_for(0, 1'b1);
    expect_rd(OFS_IRQ_STATUS, 8'h02);
    `CHECK(irq, 1'b0)
    expect_rd(OFS_CSR, 8'ha0);
    put_reg(OFS_CSR, 32'ha0);
    expect_rd(OFS_CSR, 8'ha0);
    put_reg(OFS_CSR, 32'h20);
    expect_rd(OFS_CSR, 8'h20);
    wait_for(0, 1'b1);
    put_reg(OFS_CSR, 32'h20);
    expect_rd(OFS_CSR, 8'ha0);
    put_reg(OFS_CSR, 32'h20);
    expect_rd(OFS_IRQ_STATUS, 8'h02);
    wait_for(0, 1'b1);
    put_reg(OFS_CSR, 32'h00);
    expect_rd(OFS_CSR, 8'h00);
    expect_rd(OFS_IRQ_STATUS, 8'h02);
    $display("test interval_mode done");
    put_reg(OFS_CSR, 32'h60);
    put_reg(OFS_COUNTER, 32'hfe);
    wait_for(0, 1'b1);
    expect_rd(OFS_IRQ_STATUS, 8'h01);
    `CHECK(pin_n, 1'b1)
    expect_rd(OFS_CSR, 8'he0);
    put_reg(OFS_CSR, 32'h68);
    put_reg(OFS_COUNTER, 32'hfe);
    wait_for(1, 1'b0);
    repeat (PIN_LEN - 1) @(posedge clk);
    `CHECK(pin_n, 1'b0)
    @(posedge clk);
    `CHECK(pin_n, 1'b1)
    expect_rd(OFS_IRQ_STATUS, 8'h04);
    expect_rd(OFS_CSR, 8'h68);
    // Servicing the counter in time keeps the pin and all requests quiet
    repeat (3) begin
      put_reg(OFS_COUNTER, 32'h0);
      repeat (400) @(posedge clk);
    end
    `CHECK(pin_n, 1'b1)
    expect_rd(OFS_IRQ_STATUS, 8'h00);
    $display("test watchdog_mode done");
    // Counts over eight divider periods, allowing for prescaler phase
    for (int k = 1; k < 8; k++) begin
      put_reg(OFS_CSR, 32'h20 | k);
      expect_rd(OFS_CSR, 8'h20 | k[7:0]);
      if (k < 5) begin
        put_reg(OFS_COUNTER, 32'h0);
        repeat (8 * (2 << PRESCALE_TAP[k])) @(posedge clk);
        bus(OFS_COUNTER, 1'b0, 32'h0);
        `CHECK(q[7:0] inside {8'h07, 8'h08, 8'h09}, 1'b1)
      end
    end
    $display("test clock_select done");
    put_reg(OFS_CSR, 32'h30);
    put_reg(OFS_COUNTER, 32'h0);
    repeat (20) begin
      sub_clk <= 1'b1;
      repeat (2) @(posedge clk);
      sub_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    bus(OFS_COUNTER, 1'b0, 32'h0);
    `CHECK(q[7:0] inside {8'h09, 8'h0a}, 1'b1)
    repeat (20) @(posedge clk);
    expect_rd(OFS_COUNTER, q[7:0]);
    $display("test sub_clock done");
    wrap_up();
  end
endmodule
